// ---- verilog/srmc_ctrl.sv ----
// host controller driving an asynchronous 32k x 8 static memory
`timescale 1ns/10ps
// Operation
// - write strobe stays high throughout every read cycle.
// - read holds chip select and output gate both low.
// - address is valid before chip select falls for a read.
// - address changes only while chip select is high.
// - chip select is low at least 9 ns before write end.
// - address is stable at least 9 ns before write end.
// - write data is stable at least 6 ns before write end.
module srmc_ctrl (
  input  wire logic                       clk_sys_i,
  input  wire logic                       sys_rst_i,
  input  wire logic                       req_valid_i,
  input  wire logic                       req_write_i,
  input  wire logic [srmc_pkg::ADDR_W-1:0] req_addr_i,
  input  wire logic [srmc_pkg::DATA_W-1:0] req_wdata_i,
  output logic                            req_ready_o,
  output logic                            rsp_valid_o,
  output logic [srmc_pkg::DATA_W-1:0]      rsp_rdata_o,
  output logic [srmc_pkg::ADDR_W-1:0]      mem_addr_o,
  output logic                            chip_select_n_o,
  output logic                            write_strobe_n_o,
  output logic                            output_gate_n_o,
  input  wire logic [srmc_pkg::DATA_W-1:0] shared_data_bus_i,
  output logic [srmc_pkg::DATA_W-1:0]      shared_data_bus_o,
  output logic                            shared_data_bus_oe_n_o
);
  import srmc_pkg::*;

  // one timer paces the write, read and turnaround phases; phases never overlap
  srmc_tmr_if tmr_if ();

  srmc_timer u_timer (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .tmr       (tmr_if.tmr)
  );

  srmc_state_t       state_r;
  srmc_state_t       state_nxt;
  logic              wr_r;
  logic              wr_nxt;

  logic [ADDR_W-1:0] addr_r;
  logic [ADDR_W-1:0] addr_nxt;
  logic [DATA_W-1:0] wdata_r;
  logic [DATA_W-1:0] wdata_nxt;

  logic              cs_n_r;
  logic              cs_n_nxt;
  logic              we_n_r;
  logic              we_n_nxt;
  logic              oe_n_r;
  logic              oe_n_nxt;
  logic              drv_n_r;
  logic              drv_n_nxt;

  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic              rsp_r;
  logic              rsp_nxt;

  // the memory drives these pins with no regard to our clock
  logic [DATA_W-1:0] din_meta_r;
  logic [DATA_W-1:0] din_sync_r;

  // pin data passes two flops before it is read
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      din_meta_r <= '0;
      din_sync_r <= '0;
    end else begin
      din_meta_r <= shared_data_bus_i;
      din_sync_r <= din_meta_r;
    end
  end

  always_comb begin
    state_nxt     = state_r;
    wr_nxt        = wr_r;
    addr_nxt      = addr_r;
    wdata_nxt     = wdata_r;
    cs_n_nxt      = cs_n_r;
    we_n_nxt      = we_n_r;
    oe_n_nxt      = oe_n_r;
    drv_n_nxt     = drv_n_r;
    rdata_nxt     = rdata_r;
    rsp_nxt       = 1'b0;
    tmr_if.start  = 1'b0;
    tmr_if.count  = '0;
    case (state_r)
      ST_IDLE: begin
        if (req_valid_i) begin
          // address moves only with all strobes high
          addr_nxt  = req_addr_i;
          wr_nxt    = req_write_i;
          wdata_nxt = req_wdata_i;
          state_nxt = ST_ADDR;
        end
      end

      ST_ADDR: begin
        // address has settled a full cycle before select falls
        cs_n_nxt = 1'b0;
        if (wr_r) begin
          we_n_nxt     = 1'b0;
          drv_n_nxt    = 1'b0;
          tmr_if.start = 1'b1;
          tmr_if.count = WR_CNT;
          state_nxt    = ST_WR;
        end else begin
          we_n_nxt     = 1'b1;
          oe_n_nxt     = 1'b0;
          drv_n_nxt    = 1'b1;
          tmr_if.start = 1'b1;
          tmr_if.count = RD_CNT;
          state_nxt    = ST_RD;
        end
      end

      ST_WR: begin
        if (tmr_if.done) begin
          // both strobes rise together; data and address still held
          we_n_nxt  = 1'b1;
          cs_n_nxt  = 1'b1;
          state_nxt = ST_WEND;
        end
      end

      ST_WEND: begin
        // data is held one cycle past the strobes for hold margin
        drv_n_nxt = 1'b1;
        state_nxt = ST_IDLE;
      end

      ST_RD: begin
        if (tmr_if.done) begin
          // the synchronised word was sampled two edges earlier
          rdata_nxt = din_sync_r;
          rsp_nxt   = 1'b1;
          cs_n_nxt  = 1'b1;
          oe_n_nxt  = 1'b1;
          state_nxt = ST_REND;
        end
      end

      ST_REND: begin
        // give the memory time to float before anyone drives
        tmr_if.start = 1'b1;
        tmr_if.count = FL_CNT;
        state_nxt    = ST_TURN;
      end

      ST_TURN: begin
        // new requests wait until the turnaround has passed
        if (tmr_if.done) begin
          state_nxt = ST_IDLE;
        end
      end

      default: begin
        // an illegal code parks every pin at its idle level
        state_nxt = ST_IDLE;
        cs_n_nxt  = 1'b1;
        we_n_nxt  = 1'b1;
        oe_n_nxt  = 1'b1;
        drv_n_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      // every strobe high and the bus released while in reset
      state_r <= ST_IDLE;
      wr_r    <= 1'b0;
      addr_r  <= '0;
      wdata_r <= '0;
      cs_n_r  <= 1'b1;
      we_n_r  <= 1'b1;
      oe_n_r  <= 1'b1;
      drv_n_r <= 1'b1;
      rdata_r <= '0;
      rsp_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      wr_r    <= wr_nxt;
      addr_r  <= addr_nxt;
      wdata_r <= wdata_nxt;
      cs_n_r  <= cs_n_nxt;
      we_n_r  <= we_n_nxt;
      oe_n_r  <= oe_n_nxt;
      drv_n_r <= drv_n_nxt;
      rdata_r <= rdata_nxt;
      rsp_r   <= rsp_nxt;
    end
  end

  // pins come straight from registers so no glitch reaches the memory
  assign req_ready_o            = (state_r == ST_IDLE);
  assign rsp_valid_o            = rsp_r;
  assign rsp_rdata_o            = rdata_r;
  assign mem_addr_o             = addr_r;
  assign chip_select_n_o        = cs_n_r;
  assign write_strobe_n_o       = we_n_r;
  assign output_gate_n_o        = oe_n_r;
  assign shared_data_bus_o      = wdata_r;
  assign shared_data_bus_oe_n_o = drv_n_r;
endmodule

// ---- verilog/srmc_pkg.sv ----
// constants and types for the static memory controller
package srmc_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int CNT_W  = 4;
  localparam int DEPTH  = 32768;

  localparam int CLK_PERIOD_NS = 20;

  // memory timing figures in ns
  localparam int ADDR_ACCESS_NS             = 12;
  localparam int WRITE_PULSE_NS             = 8;
  localparam int SELECT_BEFORE_WRITE_END_NS = 9;
  localparam int ADDRESS_BEFORE_WRITE_END_NS = 9;
  localparam int DATA_BEFORE_WRITE_END_NS   = 6;
  localparam int GATE_OFF_TO_FLOAT_DELAY_NS = 6;
  localparam int DESELECT_TO_FLOAT_DELAY_NS = 6;

  // least times and the access time round up, the float delay rounds down, never below one
  localparam int ACC_RAW = (ADDR_ACCESS_NS + CLK_PERIOD_NS - 1)
                           / CLK_PERIOD_NS;
  localparam int ACC_CYC = (ACC_RAW < 1) ? 1 : ACC_RAW;
  localparam int WP_MAX_NS =
    (SELECT_BEFORE_WRITE_END_NS > ADDRESS_BEFORE_WRITE_END_NS) ?
    SELECT_BEFORE_WRITE_END_NS : ADDRESS_BEFORE_WRITE_END_NS;
  localparam int WP_ALL_NS = (WP_MAX_NS > WRITE_PULSE_NS) ?
                             WP_MAX_NS : WRITE_PULSE_NS;
  localparam int WP_RAW = (WP_ALL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WP_CYC = (WP_RAW < 1) ? 1 : WP_RAW;
  localparam int DW_RAW = (DATA_BEFORE_WRITE_END_NS + CLK_PERIOD_NS - 1)
                          / CLK_PERIOD_NS;
  localparam int DW_CYC = (DW_RAW < 1) ? 1 : DW_RAW;
  localparam int FL_RAW = GATE_OFF_TO_FLOAT_DELAY_NS / CLK_PERIOD_NS;
  localparam int FL_CYC = (FL_RAW < 1) ? 1 : FL_RAW;
  localparam int SYNC_STAGES = 2;

  localparam logic [CNT_W-1:0] RD_CNT = CNT_W'(ACC_CYC + SYNC_STAGES);
  localparam logic [CNT_W-1:0] WR_CNT =
    CNT_W'((WP_CYC > DW_CYC) ? WP_CYC : DW_CYC);
  localparam logic [CNT_W-1:0] FL_CNT = CNT_W'(FL_CYC);

  typedef enum logic [6:0] {
    ST_IDLE  = 7'b000_0001,
    ST_ADDR  = 7'b000_0010,
    ST_WR    = 7'b000_0100,
    ST_WEND  = 7'b000_1000,
    ST_RD    = 7'b001_0000,
    ST_REND  = 7'b010_0000,
    ST_TURN  = 7'b100_0000
  } srmc_state_t;
endpackage

// ---- verilog/srmc_tmr_if.sv ----
// interface between the controller and its phase timer
`timescale 1ns/10ps
interface srmc_tmr_if;
  import srmc_pkg::*;
  logic             start;
  logic [CNT_W-1:0] count;
  logic             done;
  modport ctl (output start, output count, input done);
  modport tmr (input start, input count, output done);
endinterface

// ---- verilog/srmc_timer.sv ----
// phase timer: holds a state for a loaded number of cycles
`timescale 1ns/10ps
module srmc_timer (
  input  wire logic  clk_sys_i,
  input  wire logic  sys_rst_i,
  srmc_tmr_if.tmr    tmr
);
  import srmc_pkg::*;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (tmr.start) begin
      cnt_nxt = tmr.count;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // high in the last cycle of a timed phase
  assign tmr.done = (cnt_r == CNT_W'(1));
endmodule

// ---- verif/srmc_chk_sva.sv ----
// pin assertions for the static memory controller
`timescale 1ns/10ps
module srmc_chk (
  input logic        clk_sys_i,
  input logic        sys_rst_i,
  input logic        req_valid_i,
  input logic        req_write_i,
  input logic        req_ready_o,
  input logic        rsp_valid_o,
  input logic [14:0] mem_addr_o,
  input logic        chip_select_n_o,
  input logic        write_strobe_n_o,
  input logic        output_gate_n_o,
  input logic [7:0]  shared_data_bus_o,
  input logic        shared_data_bus_oe_n_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  wire cs = chip_select_n_o;
  wire we = write_strobe_n_o;
  wire og = output_gate_n_o;
  wire bo = shared_data_bus_oe_n_o;
  wire tk = req_valid_i && req_ready_o;
  sequence s_rd; !cs && !og && we && bo; endsequence
  sequence s_wr; !cs && !we && !bo && $stable(mem_addr_o); endsequence
  chk_rd_strobe: assert property (!cs && !og |-> we)
    else $error("strobe in read");
  chk_rd_cycle: assert property (tk && !req_write_i |=>
    ##1 s_rd [*3] ##1 (cs && og && rsp_valid_o)) else $error("read cycle");
  chk_addr_setup: assert property ($fell(cs) |-> $stable(mem_addr_o))
    else $error("address at select");
  chk_addr_move: assert property ($changed(mem_addr_o) |->
    (cs || we) && ($past(cs) || $past(we))) else $error("address moved");
  chk_wr_cycle: assert property (tk && req_write_i |=>
    ##1 s_wr ##1 (cs && we && $stable(mem_addr_o))) else $error("write");
  chk_wr_data: assert property ($rose(we) |->
    !bo && $stable(shared_data_bus_o)) else $error("write data");
  chk_bus_free: assert property (!og |-> bo && $past(bo))
    else $error("bus contention");
  chk_rsp_pulse: assert property (rsp_valid_o |=> !rsp_valid_o)
    else $error("response width");
endmodule
bind srmc_ctrl srmc_chk u_srmc_chk (
  .clk_sys_i              (clk_sys_i),
  .sys_rst_i              (sys_rst_i),
  .req_valid_i            (req_valid_i),
  .req_write_i            (req_write_i),
  .req_ready_o            (req_ready_o),
  .rsp_valid_o            (rsp_valid_o),
  .mem_addr_o             (mem_addr_o),
  .chip_select_n_o        (chip_select_n_o),
  .write_strobe_n_o       (write_strobe_n_o),
  .output_gate_n_o        (output_gate_n_o),
  .shared_data_bus_o      (shared_data_bus_o),
  .shared_data_bus_oe_n_o (shared_data_bus_oe_n_o)
);

// ---- verif/srmc_mem_model.sv ----
// behavioural static memory behind the controller pins
`timescale 1ns/10ps
module srmc_mem_model #(
  parameter int ACC_NS = 12
) (
  input  logic [14:0] addr_i,
  input  logic        cs_n_i,
  input  logic        we_n_i,
  input  logic        og_n_i,
  input  logic [7:0]  host_d_i,
  input  logic        host_oe_n_i,
  output logic [7:0]  bus_o
);
  logic [7:0]  mem [srmc_pkg::DEPTH];
  logic [14:0] a_d;
  logic        rd_dly = 1'b0;
  wire rd = !cs_n_i && !og_n_i && we_n_i;
  wire wr = !cs_n_i && !we_n_i;
  wire on = rd && rd_dly;
  always @(rd) rd_dly <= #(ACC_NS) rd;
  always @(addr_i) a_d <= #3 addr_i;
  always @(negedge wr) mem[addr_i] <= bus_o;
  // a released bus shows the inverse of the addressed word, never a held copy
  assign bus_o = !host_oe_n_i ? (on ? 8'hxx : host_d_i) :
                 on ? mem[a_d] : ~mem[a_d];
endmodule

// ---- verif/tb_top.sv ----
// self-checking bench for the static memory controller
`timescale 1ns/10ps
module tb_top;
  import srmc_pkg::*;
  logic              clk_sys_i = 1'b0;
  logic              sys_rst_i = 1'b1;
  logic              req_valid_i = 1'b0;
  logic              req_write_i = 1'b0;
  logic [ADDR_W-1:0] req_addr_i = 15'h0000;
  logic [DATA_W-1:0] req_wdata_i = 8'h00;
  logic [ADDR_W-1:0] mem_addr_o;
  logic [DATA_W-1:0] rsp_rdata_o, shared_data_bus_i, shared_data_bus_o;
  logic              req_ready_o, rsp_valid_o, chip_select_n_o;
  logic              write_strobe_n_o, output_gate_n_o;
  logic              shared_data_bus_oe_n_o;
  int                mismatches = 0;
  int                compares = 0;
  srmc_ctrl u_srmc_ctrl (
    .clk_sys_i              (clk_sys_i),
    .sys_rst_i              (sys_rst_i),
    .req_valid_i            (req_valid_i),
    .req_write_i            (req_write_i),
    .req_addr_i             (req_addr_i),
    .req_wdata_i            (req_wdata_i),
    .req_ready_o            (req_ready_o),
    .rsp_valid_o            (rsp_valid_o),
    .rsp_rdata_o            (rsp_rdata_o),
    .mem_addr_o             (mem_addr_o),
    .chip_select_n_o        (chip_select_n_o),
    .write_strobe_n_o       (write_strobe_n_o),
    .output_gate_n_o        (output_gate_n_o),
    .shared_data_bus_i      (shared_data_bus_i),
    .shared_data_bus_o      (shared_data_bus_o),
    .shared_data_bus_oe_n_o (shared_data_bus_oe_n_o)
  );
  srmc_mem_model u_srmc_mem_model (.addr_i(mem_addr_o),
    .cs_n_i(chip_select_n_o), .we_n_i(write_strobe_n_o),
    .og_n_i(output_gate_n_o), .host_d_i(shared_data_bus_o),
    .host_oe_n_i(shared_data_bus_oe_n_o), .bus_o(shared_data_bus_i));
  always #(CLK_PERIOD_NS / 2) clk_sys_i = ~clk_sys_i;
  task automatic check(string n, logic [ADDR_W:0] s, e);
    compares++;
    if (s !== e) mismatches++;
    if (s !== e) $display("Error %s expected %h seen %h", n, e, s);
  endtask
  task automatic req(logic w, logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
    @(posedge clk_sys_i);
    req_valid_i <= 1'b1;
    req_write_i <= w;
    req_addr_i <= a;
    req_wdata_i <= d;
    @(negedge clk_sys_i);
    repeat (20) if (!req_ready_o) @(negedge clk_sys_i);
    check("ready", req_ready_o, 1'b1);
    @(posedge clk_sys_i);
    req_valid_i <= 1'b0;
  endtask
  task automatic rd(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] e);
    req(1'b0, a, 8'h00);
    repeat (8) if (rsp_valid_o !== 1'b1) @(negedge clk_sys_i);
    check("read", {rsp_valid_o, rsp_rdata_o}, {1'b1, e});
  endtask
  task automatic t_reset;
    check("idle", {chip_select_n_o, write_strobe_n_o}, 2'h3);
    check("bus", {req_ready_o, shared_data_bus_oe_n_o}, 2'h3);
  endtask
  // corner addresses, back-to-back writes and an overwrite
  task automatic t_bounds;
    logic [ADDR_W-1:0] a [4] = '{15'h0000, 15'h7fff, 15'h0001, 15'h0001};
    logic [DATA_W-1:0] d [4] = '{8'ha5, 8'h5a, 8'h11, 8'h22};
    foreach (a[i]) req(1'b1, a[i], d[i]);
    foreach (a[i]) if (i != 2) rd(a[i], d[i]);
  endtask
  // reset cuts a read short; pins and response return to idle at once
  task automatic t_midrst;
    req(1'b0, 15'h7fff, 8'h00);
    @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    check("rd addr", mem_addr_o, 16'h7fff);
    check("rd pins", {chip_select_n_o, output_gate_n_o}, 2'h0);
    @(posedge clk_sys_i);
    sys_rst_i <= 1'b1;
    @(negedge clk_sys_i);
    check("rst pins", {chip_select_n_o, output_gate_n_o}, 2'h3);
    check("rst addr", mem_addr_o, 16'h0000);
    check("rst rsp", {rsp_valid_o, rsp_rdata_o}, 9'h000);
    check("rst bus", {req_ready_o, shared_data_bus_oe_n_o}, 2'h3);
    @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    rd(15'h7fff, 8'h5a);
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_sys_i);
    t_reset();
    sys_rst_i <= 1'b0;
    t_bounds();
    t_midrst();
    close_out();
  end
  initial begin
    repeat (2000) @(posedge clk_sys_i);
    mismatches++;
    close_out();
  end
endmodule
